// ==== shared/adcic_pkg.sv ====
// Constants, types and helpers shared by the converter control block.
// Overview of operation
// - Unipolar inputs give straight binary results.
// - Bipolar inputs give twos complement results.
// - Overrange saturates at FFFF or 7FFF.
// - Arrangement 111 converts single-ended against ground.
// - Arrangement 010 is bipolar against shared return.
// - Arrangement 110 is unipolar against shared return.
// - Arrangement 00X selects bipolar channel pairs.
// - Arrangement 10X selects unipolar channel pairs.
// - Channel field picks positive input of pair.
// - Bit 6 picks full or quarter bandwidth.
// - Scan runs from input 0 to last channel.
// - Temperature sensor optionally converted after last channel.
// - Scanned pairs: even input positive, odd negative.
// - Scan control 01 updates without stopping scan.
// - Changing pairing or last channel restarts scan.
// - Convert pin rising edge starts timed conversion.
// - One 14-bit configuration word, loaded serially.
package adcic_pkg;
    localparam int          CFG_W         = 14;         // Config word width.
    localparam int          RES_W         = 16;         // Result width.
    localparam int          FRAME_W       = RES_W + CFG_W; // Readback frame.
    localparam int          CNT_W         = 5;          // Frame bit counter.
    localparam logic [13:0] CFG_RESET     = 14'h3FFF;   // Config after reset.
    localparam logic [4:0]  CFG_LAST_BIT  = 5'h0D;      // Final config bit.
    localparam logic [4:0]  RES_LAST_BIT  = 5'h0F;      // Final result bit.
    localparam logic [4:0]  FRAME_END     = 5'h1F;      // Counter saturation.
    // Arrangement codes of the input field.
    localparam logic [2:0]  ARR_SGL_GND   = 3'h7;
    localparam logic [2:0]  ARR_COM_BIP   = 3'h2;
    localparam logic [2:0]  ARR_COM_UNI   = 3'h6;
    // Scan control codes.
    localparam logic [1:0]  SCAN_HOLD     = 2'h0;
    localparam logic [1:0]  SCAN_UPDATE   = 2'h1;
    localparam logic [1:0]  SCAN_TEMP     = 2'h2;
    localparam logic [1:0]  SCAN_NOTEMP   = 2'h3;
    // Result codes.
    localparam logic [15:0] CODE_UNI_TOP  = 16'hFFFF;
    localparam logic [15:0] CODE_UNI_BOT  = 16'h0000;
    localparam logic [15:0] CODE_BIP_TOP  = 16'h7FFF;
    localparam logic [15:0] CODE_BIP_BOT  = 16'hFFFF;
    localparam logic [15:0] CODE_MSB      = 16'h8000;
    // Conversion timing on the internal conversion clock.
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          CONV_TIME_NS  = 1600;
    localparam int          CONV_CYCLES   =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0]  CONV_LOAD     = 5'(CONV_CYCLES - 1);
    // Pin slots in the synchroniser vector.
    localparam int          PIN_SCK       = 0;
    localparam int          PIN_DIN       = 1;
    localparam int          PIN_CS        = 2;
    localparam int          PIN_CNV       = 3;
    localparam int          PIN_N         = 4;

    // Configuration word, bit 13 first.
    typedef struct packed {
        logic       overwrite;              // Bit 13: word carries an update.
        logic [2:0] input_arrangement_code; // Bits 12..10.
        logic [2:0] last_channel;           // Bits 9..7.
        logic       bandwidth_choice;       // Bit 6: 0 selects quarter.
        logic [2:0] ref_select;             // Bits 5..3.
        logic [1:0] scan_control;           // Bits 2..1.
        logic       readback_n;             // Bit 0: low appends config.
    } adcic_cfg_s;

    typedef enum logic [1:0] {NEG_GND, NEG_COM, NEG_PAIR} adcic_neg_e;
    typedef enum logic {CONV_IDLE, CONV_BUSY} adcic_conv_e;

    // Input selection handed to the analog multiplexer.
    typedef struct packed {
        logic       temp;       // Temperature sensor instead of inputs.
        logic [2:0] pos;        // Positive input.
        logic [2:0] neg;        // Negative input when paired.
        adcic_neg_e neg_kind;   // Source of the negative input.
        logic       bipolar;    // Twos complement coding.
    } adcic_sel_s;

    // Raw answer of the analog core, offset binary.
    typedef struct packed {
        logic [15:0] value;
        logic        over;
        logic        under;
    } adcic_raw_s;

    // Bit 11 low selects channel pairs.
    function automatic logic is_paired(input logic [2:0] arr);
        return !arr[1];
    endfunction

    // Bit 12 low selects the bipolar range.
    function automatic logic is_bipolar(input logic [2:0] arr);
        return !arr[2];
    endfunction
endpackage

// ==== core/adcic_result_coder.sv ====
// Output coding and saturation of one conversion result.
`timescale 1ns/1ps
`default_nettype none
module adcic_result_coder
    import adcic_pkg::*;
(
    input  wire adcic_raw_s raw,     // Raw answer of the analog core.
    input  wire logic       bipolar, // Twos complement requested.
    input  wire logic       temp,    // Temperature sensor result.
    output logic [15:0]     code     // Coded result.
);
    // The sensor result is always straight binary, whatever the range.
    always_comb
    begin
        if (bipolar && !temp)
        begin
            if (raw.over)
                code = CODE_BIP_TOP;
            else if (raw.under)
                code = CODE_BIP_BOT;
            else
                code = raw.value ^ CODE_MSB;
        end
        else
        begin
            if (raw.over)
                code = CODE_UNI_TOP;
            else if (raw.under)
                code = CODE_UNI_BOT;
            else
                code = raw.value;
        end
    end
endmodule
`default_nettype wire

// ==== core/adcic_control.sv ====
// Configuration port, channel sequencer and conversion timing.
`timescale 1ns/1ps
`default_nettype none
module adcic_control
    import adcic_pkg::*;
(
    input  wire logic       clock,             // 10 MHz core clock.
    input  wire logic       resetn,            // Synchronous reset.
    input  wire logic       sck_pin,           // Serial clock from host.
    input  wire logic       din_pin,           // Serial data from host.
    input  wire logic       cs_n_pin,          // Frame select from host.
    input  wire logic       convert_start_pin, // Rising edge converts.
    input  wire adcic_raw_s raw,               // Analog core answer.
    output logic            dout,              // Serial result data.
    output logic            dout_oe_n,         // Low while dout drives.
    output logic            sample_hold,       // High while converting.
    output adcic_sel_s      mux_sel,           // Multiplexer selection.
    output logic            bandwidth_choice,  // 1 full, 0 quarter.
    output logic [2:0]      ref_select         // Reference setup.
);
    // Two-stage synchronisers plus a third stage for edge detection.
    logic [PIN_N-1:0] sync1_ff;   // First stage, read only by second.
    logic [PIN_N-1:0] sync2_ff;   // Stable copies of the pins.
    logic [PIN_N-1:0] prev_ff;    // Delayed copies for edges.
    logic [PIN_N-1:0] pins;       // Pins gathered in slot order.

    assign pins = {convert_start_pin, cs_n_pin, din_pin, sck_pin};

    // Each pin gets its own identical synchroniser chain.
    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++)
        begin : g_sync
            always_ff @(posedge clock)
            begin
                // Stages reset to the idle level of their pin. Frame select
                // idles high, so dout stays released during reset and no
                // false frame edge follows the release.
                if (!resetn)
                begin
                    sync1_ff[gi] <= (gi == PIN_CS);
                    sync2_ff[gi] <= (gi == PIN_CS);
                    prev_ff[gi]  <= (gi == PIN_CS);
                end
                else
                begin
                    sync1_ff[gi] <= pins[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    prev_ff[gi]  <= sync2_ff[gi];
                end
            end
        end
    endgenerate

    logic sck_rise;   // Host shifts data in.
    logic sck_fall;   // Device shifts data out.
    logic cs_fall;    // Frame begins.
    logic selected;   // Frame in progress.
    logic cnv_rise;   // Convert request.

    assign sck_rise = sync2_ff[PIN_SCK] && !prev_ff[PIN_SCK];
    assign sck_fall = !sync2_ff[PIN_SCK] && prev_ff[PIN_SCK];
    assign cs_fall  = !sync2_ff[PIN_CS] && prev_ff[PIN_CS];
    assign selected = !sync2_ff[PIN_CS];
    assign cnv_rise = sync2_ff[PIN_CNV] && !prev_ff[PIN_CNV];

    // Serial port and configuration register state.
    adcic_cfg_s       cfg_ff,     nxt_cfg;      // Live configuration.
    logic [12:0]      shin_ff,    nxt_shin;     // Incoming config bits.
    logic [FRAME_W-1:0] shout_ff, nxt_shout;    // Outgoing frame.
    logic [CNT_W-1:0] bit_ff,     nxt_bit;      // Bits taken this frame.
    logic             wr_en_ff,   nxt_wr_en;    // Frame carries an update.
    logic             dout_ff,    nxt_dout;     // Registered data pin.
    logic             cfg_load;                 // Word completes now.
    adcic_cfg_s       new_cfg;                  // Word being completed.
    logic [15:0]      result_ff,  nxt_result;   // Last coded result.

    assign new_cfg  = adcic_cfg_s'({shin_ff, sync2_ff[PIN_DIN]});
    // A word only lands when its leading bit was high.
    assign cfg_load = selected && sck_rise && wr_en_ff
                      && (bit_ff == CFG_LAST_BIT);

    // Next state of the serial port; the counter saturates so that long
    // readback frames never wrap into a second update.
    always_comb
    begin
        nxt_cfg   = cfg_ff;
        nxt_shin  = shin_ff;
        nxt_shout = shout_ff;
        nxt_bit   = bit_ff;
        nxt_wr_en = wr_en_ff;
        nxt_dout  = dout_ff;
        if (cs_fall)
        begin
            // Frame start: result first, then config for readback.
            nxt_bit   = '0;
            nxt_wr_en = 1'b0;
            nxt_shout = {result_ff, cfg_ff};
            nxt_dout  = result_ff[RES_W-1];
        end
        else if (selected && sck_rise)
        begin
            if (bit_ff == '0)
                nxt_wr_en = sync2_ff[PIN_DIN];
            nxt_shin = {shin_ff[11:0], sync2_ff[PIN_DIN]};
            if (bit_ff != FRAME_END)
                nxt_bit = bit_ff + 5'h01;
            if (cfg_load)
                nxt_cfg = new_cfg;
        end
        else if (selected && sck_fall)
        begin
            nxt_shout = {shout_ff[FRAME_W-2:0], 1'b0};
            // Without readback, config bits are replaced by zeros.
            if (bit_ff > RES_LAST_BIT && cfg_ff.readback_n)
                nxt_dout = 1'b0;
            else
                nxt_dout = shout_ff[FRAME_W-2];
        end
    end

    // Registers of the serial port.
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            cfg_ff   <= adcic_cfg_s'(CFG_RESET);
            shin_ff  <= '0;
            shout_ff <= '0;
            bit_ff   <= '0;
            wr_en_ff <= 1'b0;
            dout_ff  <= 1'b0;
        end
        else
        begin
            cfg_ff   <= nxt_cfg;
            shin_ff  <= nxt_shin;
            shout_ff <= nxt_shout;
            bit_ff   <= nxt_bit;
            wr_en_ff <= nxt_wr_en;
            dout_ff  <= nxt_dout;
        end
    end

    // Conversion timing state.
    adcic_conv_e conv_ff, nxt_conv;   // Idle means acquiring.
    logic [4:0]  cnt_ff,  nxt_cnt;    // Cycles left in conversion.
    logic        conv_start;          // Convert edge accepted.
    logic        conv_done;           // Last conversion cycle.
    logic [15:0] coded;               // Coder output.

    // Edges during a conversion are ignored, as the sampler is busy.
    assign conv_start = cnv_rise && (conv_ff == CONV_IDLE);
    assign conv_done  = (conv_ff == CONV_BUSY) && (cnt_ff == '0);

    // Sequencer state.
    logic       seq_on_ff, nxt_seq_on;  // Scan running.
    logic       temp_en_ff, nxt_temp_en; // Sensor added to scan.
    logic [2:0] ch_ff,     nxt_ch;      // Next channel of scan.
    logic       temp_ff,   nxt_temp;    // Next slot is the sensor.
    logic       paired;                 // Pairs selected.
    logic       last_hit;               // Scan at its last channel.
    logic       restart;                // Update changed scan shape.
    adcic_sel_s cur_sel;                // Selection to present now.
    adcic_sel_s sel_ff, nxt_sel;        // Registered selection.

    assign paired   = is_paired(cfg_ff.input_arrangement_code);
    assign last_hit = paired ? (ch_ff[2:1] >= cfg_ff.last_channel[2:1])
                             : (ch_ff >= cfg_ff.last_channel);
    assign restart  = (new_cfg.input_arrangement_code[1]
                       != cfg_ff.input_arrangement_code[1])
                      || (new_cfg.last_channel != cfg_ff.last_channel);

    // Selection from configuration and scan position.
    always_comb
    begin
        cur_sel          = '0;
        cur_sel.bipolar  = is_bipolar(cfg_ff.input_arrangement_code);
        cur_sel.neg_kind = NEG_COM;
        if (cfg_ff.input_arrangement_code == ARR_SGL_GND)
            cur_sel.neg_kind = NEG_GND;
        else if (paired)
            cur_sel.neg_kind = NEG_PAIR;
        if (seq_on_ff)
        begin
            cur_sel.temp = temp_ff;
            cur_sel.pos  = paired ? {ch_ff[2:1], 1'b0} : ch_ff;
            cur_sel.neg  = {ch_ff[2:1], 1'b1};
        end
        else
        begin
            cur_sel.pos = cfg_ff.last_channel;
            cur_sel.neg = cfg_ff.last_channel ^ 3'h1;
        end
    end

    // Next state of the sequencer; a new word outranks a step taken in
    // the same cycle, so a restart is never skipped.
    always_comb
    begin
        nxt_seq_on  = seq_on_ff;
        nxt_temp_en = temp_en_ff;
        nxt_ch      = ch_ff;
        nxt_temp    = temp_ff;
        nxt_sel     = (conv_ff == CONV_BUSY) ? sel_ff : cur_sel;
        if (cfg_load)
        begin
            if (new_cfg.scan_control == SCAN_HOLD)
                nxt_seq_on = 1'b0;
            else if (new_cfg.scan_control != SCAN_UPDATE)
            begin
                nxt_seq_on  = 1'b1;
                nxt_temp_en = (new_cfg.scan_control == SCAN_TEMP);
                nxt_ch      = 3'h0;
                nxt_temp    = 1'b0;
            end
            else if (restart)
            begin
                nxt_ch   = 3'h0;
                nxt_temp = 1'b0;
            end
        end
        else if (conv_start && seq_on_ff)
        begin
            if (temp_ff)
            begin
                nxt_ch   = 3'h0;
                nxt_temp = 1'b0;
            end
            else if (last_hit && temp_en_ff)
                nxt_temp = 1'b1;
            else if (last_hit)
                nxt_ch = 3'h0;
            else
                nxt_ch = paired ? ch_ff + 3'h2 : ch_ff + 3'h1;
        end
    end

    // Registers of the sequencer.
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            seq_on_ff  <= 1'b0;
            temp_en_ff <= 1'b0;
            ch_ff      <= 3'h0;
            temp_ff    <= 1'b0;
            sel_ff     <= '0;
        end
        else
        begin
            seq_on_ff  <= nxt_seq_on;
            temp_en_ff <= nxt_temp_en;
            ch_ff      <= nxt_ch;
            temp_ff    <= nxt_temp;
            sel_ff     <= nxt_sel;
        end
    end

    adcic_result_coder u_coder
    (
        .raw     (raw),
        .bipolar (sel_ff.bipolar),
        .temp    (sel_ff.temp),
        .code    (coded)
    );

    // Conversion timer; the result is caught in its last cycle.
    always_comb
    begin
        nxt_conv   = conv_ff;
        nxt_cnt    = cnt_ff;
        nxt_result = result_ff;
        if (conv_start)
        begin
            nxt_conv = CONV_BUSY;
            nxt_cnt  = CONV_LOAD;
        end
        else if (conv_done)
        begin
            nxt_conv   = CONV_IDLE;
            nxt_result = coded;
        end
        else if (conv_ff == CONV_BUSY)
            nxt_cnt = cnt_ff - 5'h01;
    end

    // Registers of the conversion timer.
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            conv_ff   <= CONV_IDLE;
            cnt_ff    <= '0;
            result_ff <= '0;
        end
        else
        begin
            conv_ff   <= nxt_conv;
            cnt_ff    <= nxt_cnt;
            result_ff <= nxt_result;
        end
    end

    assign dout             = dout_ff;
    assign dout_oe_n        = !selected;
    assign sample_hold      = (conv_ff == CONV_BUSY);
    assign mux_sel          = sel_ff;
    assign bandwidth_choice = cfg_ff.bandwidth_choice;
    assign ref_select       = cfg_ff.ref_select;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_start;
        conv_start;
    endsequence
    sequence s_done;
        ##CONV_CYCLES conv_done;
    endsequence

    property p_conv_len;
        s_start |-> s_done;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");

    property p_uni_top;
        conv_done && !sel_ff.bipolar && raw.over |=> result_ff == CODE_UNI_TOP;
    endproperty
    a_uni_top: assert property (p_uni_top)
        else $error("unipolar overrange not saturated");

    property p_bip_top;
        conv_done && sel_ff.bipolar && !sel_ff.temp && raw.over
            |=> result_ff == CODE_BIP_TOP;
    endproperty
    a_bip_top: assert property (p_bip_top)
        else $error("bipolar overrange not saturated");

    property p_bip_code;
        conv_done && sel_ff.bipolar && !sel_ff.temp && !raw.over && !raw.under
            |=> result_ff == ($past(raw.value) ^ CODE_MSB);
    endproperty
    a_bip_code: assert property (p_bip_code)
        else $error("bipolar code not twos complement");

    property p_uni_code;
        conv_done && !sel_ff.bipolar && !raw.over && !raw.under
            |=> result_ff == $past(raw.value);
    endproperty
    a_uni_code: assert property (p_uni_code)
        else $error("unipolar code not straight binary");

    property p_pair_even;
        seq_on_ff && paired && !temp_ff
            |-> !cur_sel.pos[0] && cur_sel.neg == (cur_sel.pos | 3'h1);
    endproperty
    a_pair_even: assert property (p_pair_even)
        else $error("scanned pair not even positive");

    property p_gnd;
        cfg_ff.input_arrangement_code == ARR_SGL_GND
            |-> cur_sel.neg_kind == NEG_GND && !cur_sel.bipolar;
    endproperty
    a_gnd: assert property (p_gnd)
        else $error("single-ended ground not selected");

    property p_restart;
        cfg_load && new_cfg.scan_control == SCAN_UPDATE && restart
            |=> ch_ff == 3'h0 && !temp_ff;
    endproperty
    a_restart: assert property (p_restart)
        else $error("scan did not restart");

    property p_keep;
        cfg_load && new_cfg.scan_control == SCAN_UPDATE && !restart
            && seq_on_ff |=> seq_on_ff && $stable(ch_ff);
    endproperty
    a_keep: assert property (p_keep)
        else $error("update disturbed the scan");
endmodule
`default_nettype wire

// ==== sim/adcic_host_model.sv ====
// Host controller model that drives the serial configuration port.
`timescale 1ns/1ps
`default_nettype none
module adcic_host_model
(
    input  wire logic clock,
    input  wire logic dout,
    output logic      sck_pin,
    output logic      din_pin,
    output logic      cs_n_pin
);
    // Idle: frame deselected and the serial clock standing still.
    initial
    begin
        sck_pin  = 1'b0;
        din_pin  = 1'b0;
        cs_n_pin = 1'b1;
    end

    // Waits n rising edges, then steps just past the last one.
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // One 30-bit frame; the word goes out bit 13 first.
    task automatic xfer(input logic [13:0] w, output logic [29:0] rd);
        cs_n_pin = 1'b0;
        step(4);
        for (int i = 29; i >= 0; i--)
        begin
            // Data is zero past the word so that no update begins.
            din_pin = (i >= 16) ? w[i-16] : 1'b0;
            rd[i] = dout;
            step(1);
            sck_pin = 1'b1;
            step(4);
            sck_pin = 1'b0;
            step(3);
        end
        cs_n_pin = 1'b1;
        // The released data line is flipped so a stale value never helps.
        din_pin = ~din_pin;
        step(4);
    endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adcic_pkg::*;
    logic        clock = 1'b0;
    logic        resetn, convert_start_pin, sample_hold;
    logic        sck_pin, din_pin, cs_n_pin, dout, dout_oe_n;
    logic        bandwidth_choice;
    logic [2:0]  ref_select;
    adcic_raw_s  raw;
    adcic_sel_s  mux_sel;
    logic [29:0] rd;
    logic [13:0] cfg_now;
    int          n_fail = 0;
    int          checked = 0;

    always #50 clock = ~clock;

    adcic_control adcic_control_inst (.clock(clock), .resetn(resetn),
        .sck_pin(sck_pin), .din_pin(din_pin), .cs_n_pin(cs_n_pin),
        .convert_start_pin(convert_start_pin), .raw(raw), .dout(dout),
        .dout_oe_n(dout_oe_n), .sample_hold(sample_hold),
        .mux_sel(mux_sel), .bandwidth_choice(bandwidth_choice),
        .ref_select(ref_select));
    adcic_host_model adcic_host_model_inst (.clock(clock), .dout(dout),
        .sck_pin(sck_pin), .din_pin(din_pin), .cs_n_pin(cs_n_pin));

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Counts one comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] got, exp, input string s);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s %h not %h", $time, s, got, exp);
        end
    endtask

    // Writes a word that reads the configuration back with each result.
    task automatic cfg(input logic [2:0] a, l, input logic b,
                       input logic [2:0] r, input logic [1:0] s);
        cfg_now = {1'b1, a, l, b, r, s, 1'b0};
        adcic_host_model_inst.xfer(cfg_now, rd);
        step(4);
    endtask

    // Reads one frame with the data line low; config follows the result.
    task automatic rres(input logic [15:0] exp);
        adcic_host_model_inst.xfer(14'h0000, rd);
        check(rd[29:14], exp, "result");
        check(16'(rd[13:0]), 16'(cfg_now), "readback");
    endtask

    // Next slot shown to the multiplexer; pos ignored on the sensor.
    task automatic sel(input logic t, input logic [2:0] p);
        check(16'(mux_sel.temp), 16'(t), "temp");
        if (!t)
            check(16'(mux_sel.pos), 16'(p), "pos");
    endtask

    // One conversion; a second edge while busy has to be ignored.
    // Range flags are {over, under}; quarter bandwidth quarters the rate.
    task automatic conv(input logic [15:0] v, input logic [1:0] ou);
        raw = '{v, ou[1], ou[0]};
        if (!bandwidth_choice)
            step(66);
        convert_start_pin = 1'b1;
        step(3);
        check(16'(sample_hold), 16'h0001, "hold high");
        convert_start_pin = 1'b0;
        step(2);
        convert_start_pin = 1'b1;
        step(14);
        check(16'(sample_hold), 16'h0000, "hold low");
        convert_start_pin = 1'b0;
        step(3);
    endtask

    task automatic close_out;
        $display("checked %0d, n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog sized well above the roughly 6200 cycles of the tests.
    initial
    begin
        step(30000);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out();
    end

    initial
    begin
        resetn = 1'b0;
        convert_start_pin = 1'b0;
        raw = '0;
        step(12);
        resetn = 1'b1;
        step(2);
        check(16'(bandwidth_choice), 16'h0001, "bw");
        check(16'(ref_select), 16'h0007, "ref");
        check(16'(dout_oe_n), 16'h0001, "oe idle");
        $display("test reset done");
        // Single-ended scan over 0..2 with the sensor, then wrap.
        cfg(3'h7, 3'h2, 1'b0, 3'h5, SCAN_TEMP);
        check(16'(bandwidth_choice), 16'h0000, "bw");
        check(16'(ref_select), 16'h0005, "ref");
        check(16'(mux_sel.neg_kind), 16'(NEG_GND), "kind");
        for (int i = 0; i < 5; i++)
        begin
            sel(i == 3, (i == 4) ? 3'h0 : 3'(i));
            conv(16'h1234 + 16'(i), 2'h0);
        end
        rres(16'h1238);
        $display("test single done");
        // Bipolar, then unipolar, against the shared return: coding and saturation.
        cfg(3'h2, 3'h1, 1'b1, 3'h3, SCAN_NOTEMP);
        check(16'(mux_sel.bipolar), 16'h0001, "bip");
        check(16'(mux_sel.neg_kind), 16'(NEG_COM), "kind");
        conv(16'h8001, 2'h0);
        rres(16'h0001);
        conv(16'h0000, 2'h2);
        rres(16'h7FFF);
        sel(1'b0, 3'h0);
        conv(16'h0000, 2'h1);
        rres(16'hFFFF);
        cfg(3'h6, 3'h0, 1'b1, 3'h3, SCAN_NOTEMP);
        check(16'(mux_sel.bipolar), 16'h0000, "bip");
        check(16'(mux_sel.neg_kind), 16'(NEG_COM), "kind");
        conv(16'h0000, 2'h2);
        rres(16'hFFFF);
        conv(16'h0000, 2'h1);
        rres(16'h0000);
        $display("test common done");
        // Paired scans to odd last channel 5; the low field bit is ignored.
        for (int a = 0; a < 8; a++)
        begin
            if (a[1] == 1'b1)
                continue;
            cfg(3'(a), 3'h5, 1'b1, 3'h1, SCAN_NOTEMP);
            check(16'(mux_sel.bipolar), 16'(!a[2]), "bip");
            check(16'(mux_sel.neg_kind), 16'(NEG_PAIR), "kind");
            for (int k = 0; k < 4; k++)
            begin
                sel(1'b0, 3'(2 * (k % 3)));
                check(16'(mux_sel.neg), 16'(2 * (k % 3) + 1), "neg");
                conv(16'h4000, 2'h0);
            end
        end
        // Fixed pair: the channel field names the positive input.
        for (int l = 0; l < 2; l++)
        begin
            cfg(3'h4, 3'(l), 1'b1, 3'h1, SCAN_HOLD);
            sel(1'b0, 3'(l));
            check(16'(mux_sel.neg), 16'(l ^ 1), "neg");
        end
        $display("test pairs done");
        // Updates during a scan: keep position, restart on new last.
        cfg(3'h7, 3'h3, 1'b1, 3'h2, SCAN_NOTEMP);
        conv(16'h0100, 2'h0);
        conv(16'h0200, 2'h0);
        cfg(3'h7, 3'h3, 1'b1, 3'h6, SCAN_UPDATE);
        sel(1'b0, 3'h2);
        check(16'(ref_select), 16'h0006, "ref");
        cfg(3'h7, 3'h4, 1'b1, 3'h6, SCAN_UPDATE);
        sel(1'b0, 3'h0);
        // A frame whose first data bit is low must not reconfigure.
        adcic_host_model_inst.xfer(14'h0038, rd);
        check(16'(ref_select), 16'h0006, "ref");
        // Readback off: bits after the result come out as zeros.
        adcic_host_model_inst.xfer(14'h3E73, rd);
        adcic_host_model_inst.xfer(14'h0000, rd);
        check(rd[29:14], 16'h0200, "result");
        check(16'(rd[13:0]), 16'h0000, "no readback");
        $display("test update done");
        close_out();
    end
endmodule
`default_nettype wire
